// *** sim/tb_top.sv ***
// Self-checking bench for the bank1 status, protection and unlock block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import bank1_pkg::*;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	localparam logic [31:0] OPT_VALUE = 32'hA5C3_0F1E;
	logic [31:0] opt_value = OPT_VALUE;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata;
	logic reg_rvalid;
	logic op_begin = 1'b0;
	logic op_end = 1'b0;
	logic op_prot = 1'b0;
	logic op_unerased = 1'b0;
	logic ctl_locked, ctl_start, irq;
	logic [2:0] ctl_cmd;
	logic [31:0] rd_val;
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;
	bank1_status_unlock dut_u (.CLK(clk), .NRST(nrst), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .OPT_PROTECT(opt_value),
		.OP_BEGIN(op_begin), .OP_END(op_end), .OP_PROT_ERR(op_prot), .OP_UNERASED_ERR(op_unerased),
		.CTL_LOCKED(ctl_locked), .CTL_START(ctl_start), .CTL_CMD(ctl_cmd), .IRQ(irq));
	// 100 ns period
	always #50 clk = ~clk;
	// Hang guard, well above the fewer than two hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			summarize();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk("read valid", 32'h1, {31'h0, reg_rvalid});
		rd_val = reg_rdata;
	endtask : rd
	task automatic st(input logic [31:0] exp);
		rd(OFS_STATUS);
		chk("status", exp, rd_val);
	endtask : st
	// Unlock needs a few cycles to reach the lock output
	task automatic settle();
		repeat (3) @(negedge clk);
	endtask : settle
	task automatic eng(input logic b, input logic e, input logic p, input logic u);
		@(posedge clk);
		op_begin <= b;
		op_end <= e;
		op_prot <= p;
		op_unerased <= u;
		@(posedge clk);
		op_begin <= 1'b0;
		op_end <= 1'b0;
		op_prot <= 1'b0;
		op_unerased <= 1'b0;
	endtask : eng
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(OFS_PROTECT);
		chk("protect", OPT_VALUE, rd_val);
		wr(OFS_PROTECT, ~OPT_VALUE);
		rd(OFS_PROTECT);
		chk("protect ro", OPT_VALUE, rd_val);
		st(32'h0);
		rd(OFS_KEY);
		chk("key read", 32'h0, rd_val);
		rd(8'h60);
		chk("unmapped", 32'h0, rd_val);
		chk("lock reset", 32'h1, {31'h0, ctl_locked});
		$display("test reset done");
	endtask : t_reset
	task automatic t_unlock();
		wr(OFS_KEY, UNLOCK_KEY_SECOND);
		wr(OFS_KEY, UNLOCK_KEY_FIRST);
		wr(OFS_KEY, 32'h0000_1234);
		wr(OFS_CONTROL, 32'h0000_0002);
		settle();
		chk("lock wrong key", 32'h1, {31'h0, ctl_locked});
		chk("cmd while locked", 32'h0, {29'h0, ctl_cmd});
		wr(OFS_KEY, UNLOCK_KEY_FIRST);
		wr(OFS_KEY, UNLOCK_KEY_SECOND);
		settle();
		chk("lock unlocked", 32'h0, {31'h0, ctl_locked});
		// First word while unlocked must not arm the sequence
		wr(OFS_KEY, UNLOCK_KEY_FIRST);
		wr(OFS_CONTROL, 32'h0000_0080);
		wr(OFS_KEY, UNLOCK_KEY_SECOND);
		settle();
		chk("lock relocked", 32'h1, {31'h0, ctl_locked});
		wr(OFS_KEY, UNLOCK_KEY_FIRST);
		wr(OFS_KEY, UNLOCK_KEY_SECOND);
		settle();
		chk("lock again", 32'h0, {31'h0, ctl_locked});
		$display("test unlock done");
	endtask : t_unlock
	task automatic t_erase();
		wr(OFS_CONTROL, 32'h0000_0042);
		st(32'h1);
		chk("start set", 32'h1, {31'h0, ctl_start});
		chk("cmd", 32'h2, {29'h0, ctl_cmd});
		wr(OFS_STATUS, 32'h0000_0001);
		st(32'h1);
		eng(1'b0, 1'b1, 1'b0, 1'b0);
		st(32'h20);
		chk("start cleared", 32'h0, {31'h0, ctl_start});
		wr(OFS_STATUS, 32'h0);
		st(32'h20);
		wr(OFS_STATUS, 32'h20);
		st(32'h0);
		$display("test erase done");
	endtask : t_erase
	task automatic t_errors();
		wr(OFS_CONTROL, 32'h0000_0400);
		eng(1'b1, 1'b0, 1'b0, 1'b0);
		st(32'h1);
		chk("irq idle", 32'h0, {31'h0, irq});
		eng(1'b0, 1'b1, 1'b1, 1'b0);
		st(32'h10);
		chk("irq error", 32'h1, {31'h0, irq});
		wr(OFS_STATUS, 32'h10);
		st(32'h0);
		chk("irq cleared", 32'h0, {31'h0, irq});
		eng(1'b0, 1'b1, 1'b0, 1'b1);
		st(32'h4);
		wr(OFS_STATUS, 32'h4);
		st(32'h0);
		wr(OFS_CONTROL, 32'h0000_1000);
		eng(1'b0, 1'b1, 1'b0, 1'b0);
		settle();
		chk("irq done", 32'h1, {31'h0, irq});
		wr(OFS_STATUS, 32'h20);
		settle();
		chk("irq done cleared", 32'h0, {31'h0, irq});
		$display("test errors done");
	endtask : t_errors
	// Mid-run reset with a new option setting; state clears and protection reloads
	task automatic t_rereset();
		wr(OFS_CONTROL, 32'h0000_1401);
		eng(1'b1, 1'b1, 1'b1, 1'b0);
		st(32'h10);
		chk("irq before reset", 32'h1, {31'h0, irq});
		chk("cmd before reset", 32'h1, {29'h0, ctl_cmd});
		@(posedge clk);
		nrst <= 1'b0;
		opt_value <= ~OPT_VALUE;
		repeat (3) @(negedge clk);
		chk("lock in reset", 32'h1, {31'h0, ctl_locked});
		chk("irq in reset", 32'h0, {31'h0, irq});
		chk("cmd in reset", 32'h0, {29'h0, ctl_cmd});
		chk("rvalid in reset", 32'h0, {31'h0, reg_rvalid});
		@(posedge clk);
		nrst <= 1'b1;
		rd(OFS_PROTECT);
		chk("protect reload", ~OPT_VALUE, rd_val);
		st(32'h0);
		chk("lock after reset", 32'h1, {31'h0, ctl_locked});
		$display("test rereset done");
	endtask : t_rereset
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	// Reset held 20 cycles, then the scenarios in turn
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_unlock();
		t_erase();
		t_errors();
		t_rereset();
		summarize();
	end
endmodule : tb_top
`default_nettype wire

// *** src/bank1_key_seq.sv ***
// Two-word unlock key sequence recogniser
`timescale 1ns/1ns
`default_nettype none
module bank1_key_seq (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Key path
	key_path_if.seq kp
);
	import bank1_pkg::*;

	typedef enum logic [0:0] {WAIT_FIRST, WAIT_SECOND} key_state_t;
	typedef struct packed {
		key_state_t st;
		logic unlock;
	} key_regs_t;

	key_regs_t r_reg;
	key_regs_t r_next;

	// ----------------------------------------
	// Sequence tracking
	// ----------------------------------------
	// Any wrong word restarts the hunt, so stray writes never unlock
	always_comb begin
		r_next = r_reg;
		r_next.unlock = 1'b0;
		if (kp.key_wr) begin
			unique case (r_reg.st)
				WAIT_FIRST: begin
					if (kp.key_data == UNLOCK_KEY_FIRST) r_next.st = WAIT_SECOND; // R9
				end
				WAIT_SECOND: begin
					r_next.st = WAIT_FIRST;
					r_next.unlock = (kp.key_data == UNLOCK_KEY_SECOND); // R9
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r_reg <= '{st: WAIT_FIRST, unlock: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign kp.unlock = r_reg.unlock;

	// The two key words may be any number of idle cycles apart, so check each step on its own
	a_unlock_needs_keys: assert property (@(posedge clk) disable iff (!nrst) // R9
		r_reg.unlock |-> $past(r_reg.st) == WAIT_SECOND && $past(kp.key_wr)
			&& $past(kp.key_data) == UNLOCK_KEY_SECOND)
		else $error("unlock without the two key words");
	a_first_key_arms: assert property (@(posedge clk) disable iff (!nrst) // R9
		r_reg.st == WAIT_SECOND && $past(r_reg.st) == WAIT_FIRST |-> $past(kp.key_wr)
			&& $past(kp.key_data) == UNLOCK_KEY_FIRST)
		else $error("sequence armed without the first key word");
endmodule : bank1_key_seq
`default_nettype wire

// *** src/bank1_pkg.sv ***
// Shared constants for the bank1 status, protection and unlock block
package bank1_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_PROTECT = 8'h20;
	localparam logic [7:0] OFS_KEY = 8'h44;
	localparam logic [7:0] OFS_STATUS = 8'h4C;
	localparam logic [7:0] OFS_CONTROL = 8'h50;
	// ----------------------------------------
	// Status field positions
	// ----------------------------------------
	localparam int ST_BUSY = 0;
	localparam int ST_UNERASED = 2;
	localparam int ST_PROTECT = 4;
	localparam int ST_DONE = 5;
	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int CT_CMD_LO = 0;
	localparam int CT_START = 6;
	localparam int CT_LOCK = 7;
	localparam int CT_ERR_IE = 10;
	localparam int CT_DONE_IE = 12;
	// ----------------------------------------
	// Reset values and unlock keys
	// ----------------------------------------
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0080;
	localparam logic [31:0] UNLOCK_KEY_FIRST = 32'h4567_0123;
	localparam logic [31:0] UNLOCK_KEY_SECOND = 32'hCDEF_89AB;
endpackage : bank1_pkg

// *** src/bank1_status_unlock.sv ***
// Bank1 protection image, unlock key, status and control bits
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1: Protection word at 0x20 is read-only, loaded from option bytes after reset.
// R2: Status register sits at 0x4C and resets to all zeros.
// R3: Software uses only full 32-bit word accesses on these registers.
// R4: Status bit 5 sets on successful operation end; writing 1 clears it.
// R5: Status bit 4 sets on protected-page access; writing 1 clears it.
// R6: Status bit 2 sets on programming unerased location; writing 1 clears it.
// R7: Status bit 0 shows the flash is busy.
// R8: Software writes reserved status bits 3 and 1 only as zero.
// R9: Only key words 0x45670123 then 0xCDEF89AB unlock the control register.
// R10: Lock bit resets to one, clears on unlock, software may set it.
// R11: Hardware clears the erase-launch bit when busy returns to zero.
// R12: Enabled interrupts fire on operation end and on errors.
// R13: Writing 0 leaves flags; busy holds from operation start to completion.
// R14: Wrong key words leave the lock set; key reads return zero.
module bank1_status_unlock (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Register port (word accesses only)
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	output logic REG_RVALID,
	// Option byte protection setting
	input wire logic [31:0] OPT_PROTECT,
	// Flash engine status, same clock domain
	input wire logic OP_BEGIN,
	input wire logic OP_END,
	input wire logic OP_PROT_ERR,
	input wire logic OP_UNERASED_ERR,
	// Controller outputs
	output logic CTL_LOCKED,
	output logic CTL_START,
	output logic [2:0] CTL_CMD,
	output logic IRQ
);
	import bank1_pkg::*;

	typedef struct packed {
		logic loaded;
		logic [31:0] protect;
		logic lock;
		logic start;
		logic done_ie;
		logic err_ie;
		logic [2:0] cmd;
		logic busy;
		logic done;
		logic prot;
		logic unerased;
		logic [31:0] rdata;
		logic rvalid;
	} regs_t;

	regs_t r_reg;
	regs_t r_next;
	key_path_if kp ();

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic wr_key;
	logic wr_status;
	logic wr_control;
	logic [31:0] status_view;
	logic [31:0] control_view;

	assign wr_key = REG_WR && REG_ADDR == OFS_KEY;
	assign wr_status = REG_WR && REG_ADDR == OFS_STATUS;
	assign wr_control = REG_WR && REG_ADDR == OFS_CONTROL;
	assign kp.key_wr = wr_key && r_reg.lock; // R14
	assign kp.key_data = REG_WDATA;

	// Read views; reserved bits read as zero
	always_comb begin
		status_view = STATUS_RESET;
		status_view[ST_BUSY] = r_reg.busy; // R7
		status_view[ST_UNERASED] = r_reg.unerased;
		status_view[ST_PROTECT] = r_reg.prot;
		status_view[ST_DONE] = r_reg.done;
		control_view = 32'h0000_0000;
		control_view[CT_CMD_LO +: 3] = r_reg.cmd;
		control_view[CT_START] = r_reg.start;
		control_view[CT_LOCK] = r_reg.lock;
		control_view[CT_ERR_IE] = r_reg.err_ie;
		control_view[CT_DONE_IE] = r_reg.done_ie;
	end

	// ----------------------------------------
	// Key sequencer
	// ----------------------------------------
	bank1_key_seq u_key_seq (
		.clk(CLK),
		.nrst(NRST),
		.kp(kp)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Hardware set wins over a software clear in the same cycle
	always_comb begin
		r_next = r_reg;
		r_next.rvalid = REG_RD;
		r_next.rdata = 32'h0000_0000;
		// Option bytes captured once after release, not under reset
		if (!r_reg.loaded) begin
			r_next.protect = OPT_PROTECT; // R1
			r_next.loaded = 1'b1;
		end
		// Read mux; key and unmapped offsets read zero
		if (REG_RD) begin
			unique case (REG_ADDR)
				OFS_PROTECT: r_next.rdata = r_reg.protect; // R1
				OFS_STATUS: r_next.rdata = status_view; // R2
				OFS_CONTROL: r_next.rdata = control_view;
				default: r_next.rdata = 32'h0000_0000; // R14
			endcase
		end
		// Write-one-to-clear flags; zeros leave them alone
		if (wr_status) begin
			if (REG_WDATA[ST_DONE]) r_next.done = 1'b0; // R4 R13
			if (REG_WDATA[ST_PROTECT]) r_next.prot = 1'b0; // R5 R13
			if (REG_WDATA[ST_UNERASED]) r_next.unerased = 1'b0; // R6 R13
		end
		// Control writes other than the lock bit take effect only while unlocked
		if (wr_control) begin
			if (!r_reg.lock) begin
				r_next.cmd = REG_WDATA[CT_CMD_LO +: 3];
				r_next.done_ie = REG_WDATA[CT_DONE_IE];
				r_next.err_ie = REG_WDATA[CT_ERR_IE];
				if (REG_WDATA[CT_START] && !r_reg.start) begin
					r_next.start = 1'b1;
					r_next.busy = 1'b1; // R13
				end
			end
			if (REG_WDATA[CT_LOCK]) r_next.lock = 1'b1; // R10
		end
		if (kp.unlock) r_next.lock = 1'b0; // R10
		if (OP_BEGIN) r_next.busy = 1'b1; // R13
		// Operation end drops busy, launch bit and raises flags
		if (OP_END) begin
			r_next.busy = 1'b0; // R7
			r_next.start = 1'b0; // R11
			if (OP_PROT_ERR) r_next.prot = 1'b1; // R5
			if (OP_UNERASED_ERR) r_next.unerased = 1'b1; // R6
			if (!OP_PROT_ERR && !OP_UNERASED_ERR) r_next.done = 1'b1; // R4
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			r_reg <= '0;
			r_reg.lock <= CONTROL_RESET[CT_LOCK]; // R10
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign REG_RDATA = r_reg.rdata;
	assign REG_RVALID = r_reg.rvalid;
	assign CTL_LOCKED = r_reg.lock;
	assign CTL_START = r_reg.start;
	assign CTL_CMD = r_reg.cmd;
	// Level interrupt; stays up until software clears the flag
	assign IRQ = (r_reg.done_ie && r_reg.done) || (r_reg.err_ie && (r_reg.prot || r_reg.unerased)); // R12

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_protect_holds: assert property (@(posedge CLK) disable iff (!NRST) // R1
		r_reg.loaded && $past(r_reg.loaded) |-> $stable(r_reg.protect))
		else $error("protection word changed after load");
	a_status_read_clean: assert property (@(posedge CLK) disable iff (!NRST) // R2
		REG_RD && REG_ADDR == OFS_STATUS |=> REG_RVALID && REG_RDATA[31:6] == 26'h0 && !REG_RDATA[3] && !REG_RDATA[1])
		else $error("status reserved bits not zero");
	a_done_sets: assert property (@(posedge CLK) disable iff (!NRST) // R4
		OP_END && !OP_PROT_ERR && !OP_UNERASED_ERR |=> r_reg.done && !r_reg.busy)
		else $error("done flag not set at operation end");
	a_prot_sets: assert property (@(posedge CLK) disable iff (!NRST) // R5
		OP_END && OP_PROT_ERR |=> r_reg.prot && (!r_reg.done || $past(r_reg.done)))
		else $error("protection flag not set");
	a_unerased_sets: assert property (@(posedge CLK) disable iff (!NRST) // R6
		OP_END && OP_UNERASED_ERR |=> r_reg.unerased)
		else $error("program error flag not set");
	a_busy_on_start: assert property (@(posedge CLK) disable iff (!NRST) // R7
		wr_control && !r_reg.lock && REG_WDATA[CT_START] && !r_reg.start && !OP_END |=> r_reg.busy && CTL_START)
		else $error("busy not raised on launch");
	a_zero_keeps_flag: assert property (@(posedge CLK) disable iff (!NRST) // R13
		wr_status && !REG_WDATA[ST_DONE] && !OP_END |=> $stable(r_reg.done))
		else $error("writing zero changed done flag");
	a_start_follows_busy: assert property (@(posedge CLK) disable iff (!NRST) // R11
		$fell(r_reg.busy) |-> !r_reg.start)
		else $error("launch bit outlived busy");
	a_unlock_clears: assert property (@(posedge CLK) disable iff (!NRST) // R10
		kp.unlock && !(wr_control && REG_WDATA[CT_LOCK]) |=> !CTL_LOCKED)
		else $error("lock not cleared by key sequence");
	a_wrong_key_locked: assert property (@(posedge CLK) disable iff (!NRST) // R14
		r_reg.lock && wr_key && REG_WDATA != UNLOCK_KEY_SECOND |=> CTL_LOCKED)
		else $error("wrong key released the lock");
	a_irq_done: assert property (@(posedge CLK) disable iff (!NRST) // R12
		r_reg.done_ie && r_reg.done |-> IRQ)
		else $error("done interrupt missing");
	a_irq_quiet: assert property (@(posedge CLK) disable iff (!NRST) // R12
		!r_reg.done_ie && !r_reg.err_ie |-> !IRQ)
		else $error("interrupt without any enable");
	a_busy_holds: assert property (@(posedge CLK) disable iff (!NRST) // R13
		r_reg.busy && !OP_END |=> r_reg.busy)
		else $error("busy dropped before operation end");
	a_done_needs_end: assert property (@(posedge CLK) disable iff (!NRST) // R4
		$rose(r_reg.done) |-> $past(OP_END) && !$past(OP_PROT_ERR) && !$past(OP_UNERASED_ERR))
		else $error("done flag rose without clean operation end");
endmodule : bank1_status_unlock
`default_nettype wire

// *** src/key_path_if.sv ***
// Carrier between the register front end and the key sequencer
`timescale 1ns/1ns
`default_nettype none
interface key_path_if;
	logic key_wr;
	logic [31:0] key_data;
	logic unlock;
	modport seq (input key_wr, input key_data, output unlock);
	modport front (output key_wr, output key_data, input unlock);
endinterface : key_path_if
`default_nettype wire
